/* File: src/eawc_pkg.sv */
package eawc_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int ANGLE_W = 9;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] ADDR_CALC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'h1;
  localparam logic [3:0] ADDR_PERIOD_SET = 4'h2;
  localparam logic [3:0] ADDR_ANGLE = 4'h3;
  localparam logic [3:0] ADDR_AMPLITUDE = 4'h4;
  localparam logic [3:0] ADDR_CAPTURE = 4'h5;
  localparam logic [3:0] ADDR_SINE_DATA = 4'h6;
  localparam logic [3:0] ADDR_PWM_PERIOD = 4'h7;
  localparam logic [3:0] ADDR_CMP_U = 4'h8;
  localparam logic [3:0] ADDR_CMP_V = 4'h9;
  localparam logic [3:0] ADDR_CMP_W = 4'ha;

  // ==========================================================
  // Field positions
  localparam int CC_SOFT_START = 3;
  localparam int CC_BUSY = 2;
  localparam int CC_SYNC_OFF = 1;
  localparam int CC_IRQ_SEL = 0;
  localparam int TC_DIR = 7;
  localparam int TC_ORDER = 6;
  localparam int TC_CLK_HI = 5;
  localparam int TC_CLK_LO = 4;
  localparam int TC_THREE = 3;
  localparam int TC_XFER = 2;
  localparam int TC_CALC_EN = 1;
  localparam int TC_TMR_EN = 0;
  localparam int PS_FRAC_HI = 15;
  localparam int PS_FRAC_LO = 12;
  localparam int PS_BASE_HI = 11;
  localparam int PS_BASE_LO = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
  localparam logic [1:0] CALC_CTRL_RST = 2'h0;
  localparam logic [15:0] PERIOD_SET_RST = 16'h0010;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [8:0] ANGLE_RST = 9'h000;

  // ==========================================================
  // Angle and timing constants
  localparam logic [8:0] ANGLE_MAX = 9'h17f;
  localparam logic [9:0] ANGLE_SPAN = 10'h180;
  localparam logic [8:0] ANGLE_HALF = 9'h0c0;
  localparam logic [9:0] ANGLE_120 = 10'h080;
  localparam logic [9:0] ANGLE_240 = 10'h100;
  localparam logic [11:0] BASE_MIN = 12'h010;
  localparam logic [5:0] CALC_CYCLES = 6'h23;
  localparam logic [5:0] CALC_LAST = CALC_CYCLES - 6'h01;
  localparam logic [5:0] STEP_U = 6'h01;
  localparam logic [5:0] STEP_V = 6'h02;
  localparam logic [5:0] STEP_W = 6'h03;
  localparam logic [5:0] PRESC_MASK [4] = '{6'h07, 6'h0f, 6'h1f, 6'h3f};

  // ==========================================================
  // Types
  typedef struct packed {
    logic [15:0] u;
    logic [15:0] v;
    logic [15:0] w;
  } eawc_duty_t;

  typedef enum logic [0:0] {
    CALC_IDLE = 1'b0,
    CALC_RUN = 1'b1
  } eawc_calc_state_t;

endpackage

/* File: src/eawc_sine_ram.sv */
`timescale 1ns/10ps
module eawc_sine_ram
  import eawc_pkg::*;
(
  input wire logic mclk,
  input wire logic wrEn,
  input wire logic [ANGLE_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [ANGLE_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  // ==========================================================
  // Sine table storage, one word per angle count
  logic [DATA_W-1:0] mem [int'(ANGLE_SPAN)];

  always_ff @(posedge mclk)
  begin
    if (wrEn && (wrAddr <= ANGLE_MAX))
    begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rdAddr <= ANGLE_MAX)
    begin
      rdData <= mem[rdAddr];
    end
    else
    begin
      rdData <= WORD_RST;
    end
  end

endmodule

/* File: src/eawc_angle_calc.sv */
`timescale 1ns/10ps
// Summary of operation
// - Soft start forces calculation, aborting any running
// - Busy flag readable in calculation control
// - Sync start on angle step and angle write
// - Without sync, only soft start begins calculation
// - Interrupt source: angle step or calculation end
// - Direction bit selects counting up or down
// - Phase order bit sets V/W lead or lag
// - Clock select picks prescaler, changeable while running
// - Two-phase result is sine times amplitude
// - Three-phase result is half period plus/minus half product
// - Add below angle 192, subtract from 192
// - Calc plus transfer loads results as duties
// - Compare reads return results while calc enabled
// - Timer enable counts; disable stops and clears angle
// - n of 16 steps use period m+1
// - Angle readable, writable; values above 17FH ignored
// - Amplitude scales sine, clamped to PWM period
// - Position detect captures angle counter
// - Angle spans 0 to 383 and wraps
// - Base period below 010H acts as 010H
// - One calculation lasts 35 cycles
// - V and W offset by 120 and 240 degrees
module eawc_angle_calc
  import eawc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  input wire logic posDetect,
  output logic angleIrq,
  output eawc_duty_t duty,
  output logic dutyLoad
);

  // ==========================================================
  // Functions
  function automatic logic [8:0] offsetAngle(input logic [8:0] a, input logic [9:0] off,
                                             input logic sub);
    logic [10:0] s;
    s = sub ? ({2'b00, a} + {1'b0, ANGLE_SPAN} - {1'b0, off}) : ({2'b00, a} + {1'b0, off});
    if (s >= {1'b0, ANGLE_SPAN})
    begin
      s = s - {1'b0, ANGLE_SPAN};
    end
    return s[8:0];
  endfunction

  function automatic logic [8:0] stepAngle(input logic [8:0] a, input logic down);
    logic [8:0] r;
    r = a;
    if (down)
    begin
      r = (a == ANGLE_RST) ? ANGLE_MAX : a - 9'h001;
    end
    else
    begin
      r = (a == ANGLE_MAX) ? ANGLE_RST : a + 9'h001;
    end
    return r;
  endfunction

  function automatic logic [15:0] phaseResult(input logic [15:0] sine, input logic [8:0] ang,
                                              input logic [15:0] voltage_amplitude, input logic [15:0] prd,
                                              input logic three);
    logic [31:0] prod;
    logic [15:0] scaled;
    logic [15:0] halfPrd;
    logic [15:0] halfProd;
    prod = sine * voltage_amplitude;
    scaled = prod[31:16];
    halfPrd = {1'b0, prd[15:1]};
    halfProd = {1'b0, scaled[15:1]};
    if (!three)
    begin
      return scaled;
    end
    else if (ang < ANGLE_HALF)
    begin
      return halfPrd + halfProd;
    end
    else
    begin
      return halfPrd - halfProd;
    end
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] timerCtrl;
  logic [1:0] calcCtrl;
  logic [15:0] periodSet;
  logic [15:0] amplitude;
  logic [15:0] pwmPeriod;
  logic [8:0] angle;
  logic [8:0] capture;
  eawc_duty_t result;
  eawc_duty_t work;

  logic tmrEn;
  logic waveform_calc_enable;
  logic xferEn;
  logic syncOn;
  logic wrCalcCtrl;
  logic wrTimerCtrl;
  logic angleWrOk;
  logic tmrStop;
  logic softStart;
  logic stepDone;
  logic calcStart;
  logic calcDone;
  logic xferNow;

  assign tmrEn = timerCtrl[TC_TMR_EN];
  assign waveform_calc_enable = timerCtrl[TC_CALC_EN];
  assign xferEn = waveform_calc_enable && timerCtrl[TC_XFER];
  assign syncOn = !calcCtrl[CC_SYNC_OFF];
  assign wrCalcCtrl = wrStrobe && (addr == ADDR_CALC_CTRL);
  assign wrTimerCtrl = wrStrobe && (addr == ADDR_TIMER_CTRL);
  assign angleWrOk = wrStrobe && (addr == ADDR_ANGLE) && (wrData <= {7'h00, ANGLE_MAX});
  assign tmrStop = wrTimerCtrl && tmrEn && !wrData[TC_TMR_EN];
  assign softStart = wrCalcCtrl && wrData[CC_SOFT_START];
  assign calcStart = softStart || (waveform_calc_enable && syncOn && ((tmrEn && stepDone) || angleWrOk));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      timerCtrl <= TIMER_CTRL_RST;
    end
    else if (wrTimerCtrl)
    begin
      timerCtrl <= wrData[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      calcCtrl <= CALC_CTRL_RST;
    end
    else if (wrCalcCtrl)
    begin
      calcCtrl <= {wrData[CC_SYNC_OFF], wrData[CC_IRQ_SEL]};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      periodSet <= PERIOD_SET_RST;
      amplitude <= WORD_RST;
      pwmPeriod <= WORD_RST;
    end
    else if (wrStrobe)
    begin
      if (addr == ADDR_PERIOD_SET)
      begin
        periodSet <= wrData;
      end
      if (addr == ADDR_AMPLITUDE)
      begin
        amplitude <= wrData;
      end
      if (addr == ADDR_PWM_PERIOD)
      begin
        pwmPeriod <= wrData;
      end
    end
  end

  // ==========================================================
  // Angle timer
  logic [5:0] presc;
  logic [5:0] prescMask;
  logic tick;
  logic [11:0] baseEff;
  logic [12:0] stepCnt;
  logic [12:0] periodLen;
  logic [3:0] fracAcc;
  logic [4:0] fracSum;

  assign prescMask = PRESC_MASK[timerCtrl[TC_CLK_HI:TC_CLK_LO]];
  assign tick = tmrEn && ((presc & prescMask) == prescMask);
  assign baseEff = (periodSet[PS_BASE_HI:PS_BASE_LO] < BASE_MIN) ? BASE_MIN
                   : periodSet[PS_BASE_HI:PS_BASE_LO];
  assign fracSum = {1'b0, fracAcc} + {1'b0, periodSet[PS_FRAC_HI:PS_FRAC_LO]};
  assign periodLen = {1'b0, baseEff} + {12'h000, fracSum[4]};
  assign stepDone = tick && (stepCnt == periodLen - 13'h0001);

  always_ff @(posedge mclk)
  begin
    if (rst || !tmrEn)
    begin
      presc <= 6'h00;
    end
    else
    begin
      presc <= presc + 6'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || !tmrEn)
    begin
      stepCnt <= 13'h0000;
      fracAcc <= 4'h0;
    end
    else if (stepDone)
    begin
      stepCnt <= 13'h0000;
      fracAcc <= fracSum[3:0];
    end
    else if (tick)
    begin
      stepCnt <= stepCnt + 13'h0001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      angle <= ANGLE_RST;
    end
    else if (angleWrOk)
    begin
      angle <= wrData[8:0];
    end
    else if (tmrStop)
    begin
      angle <= ANGLE_RST;
    end
    else if (stepDone)
    begin
      angle <= stepAngle(angle, timerCtrl[TC_DIR]);
    end
  end

  // ==========================================================
  // Position capture
  logic posSync1;
  logic posSync2;
  logic posPrev;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      posSync1 <= 1'b0;
      posSync2 <= 1'b0;
      posPrev <= 1'b0;
      capture <= ANGLE_RST;
    end
    else
    begin
      posSync1 <= posDetect;
      posSync2 <= posSync1;
      posPrev <= posSync2;
      if (posSync2 && !posPrev)
      begin
        capture <= angle;
      end
    end
  end

  // ==========================================================
  // Waveform arithmetic
  eawc_calc_state_t calcState;
  logic [5:0] calcCnt;
  logic [8:0] baseAngle;
  logic [15:0] ampLatch;
  logic [15:0] prdLatch;
  logic [8:0] angU;
  logic [8:0] angV;
  logic [8:0] angW;
  logic [8:0] ramAddr;
  logic [15:0] sine;
  logic ramWr;

  assign angU = baseAngle;
  assign angV = offsetAngle(baseAngle, ANGLE_120, timerCtrl[TC_ORDER]);
  assign angW = offsetAngle(baseAngle, ANGLE_240, timerCtrl[TC_ORDER]);
  assign ramAddr = (calcCnt == 6'h00) ? angU : ((calcCnt == STEP_U) ? angV : angW);
  assign ramWr = wrStrobe && (addr == ADDR_SINE_DATA);
  assign calcDone = (calcState == CALC_RUN) && (calcCnt == CALC_LAST) && !calcStart;
  assign xferNow = calcDone && xferEn;

  eawc_sine_ram sineRam (
    .mclk(mclk),
    .wrEn(ramWr),
    .wrAddr(angle),
    .wrData(wrData),
    .rdAddr(ramAddr),
    .rdData(sine)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      calcState <= CALC_IDLE;
      calcCnt <= 6'h00;
      baseAngle <= ANGLE_RST;
      ampLatch <= WORD_RST;
      prdLatch <= WORD_RST;
    end
    else if (calcStart)
    begin
      calcState <= CALC_RUN;
      calcCnt <= 6'h00;
      baseAngle <= angleWrOk ? wrData[8:0] : (stepDone ? stepAngle(angle, timerCtrl[TC_DIR])
                                                      : angle);
      ampLatch <= (amplitude > pwmPeriod) ? pwmPeriod : amplitude;
      prdLatch <= pwmPeriod;
    end
    else
    begin
      case (calcState)
        CALC_IDLE:
        begin
          calcCnt <= 6'h00;
        end
        CALC_RUN:
        begin
          if (calcCnt == CALC_LAST)
          begin
            calcState <= CALC_IDLE;
          end
          else
          begin
            calcCnt <= calcCnt + 6'h01;
          end
        end
        default:
        begin
          calcState <= CALC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      work <= '0;
    end
    else if (calcState == CALC_RUN)
    begin
      if (calcCnt == STEP_U)
      begin
        work.u <= phaseResult(sine, angU, ampLatch, prdLatch, timerCtrl[TC_THREE]);
      end
      if (calcCnt == STEP_V)
      begin
        work.v <= phaseResult(sine, angV, ampLatch, prdLatch, timerCtrl[TC_THREE]);
      end
      if (calcCnt == STEP_W)
      begin
        work.w <= phaseResult(sine, angW, ampLatch, prdLatch, timerCtrl[TC_THREE]);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      result <= '0;
    end
    else if (calcDone)
    begin
      result <= work;
    end
  end

  // ==========================================================
  // Compare registers toward the PWM stage
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      duty <= '0;
      dutyLoad <= 1'b0;
    end
    else
    begin
      dutyLoad <= 1'b0;
      if (xferNow)
      begin
        duty <= work;
        dutyLoad <= 1'b1;
      end
      else if (wrStrobe && !xferEn)
      begin
        if (addr == ADDR_CMP_U)
        begin
          duty.u <= wrData;
          dutyLoad <= 1'b1;
        end
        if (addr == ADDR_CMP_V)
        begin
          duty.v <= wrData;
          dutyLoad <= 1'b1;
        end
        if (addr == ADDR_CMP_W)
        begin
          duty.w <= wrData;
          dutyLoad <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Interrupt request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      angleIrq <= 1'b0;
    end
    else
    begin
      angleIrq <= calcCtrl[CC_IRQ_SEL] ? calcDone : (tmrEn && stepDone);
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge mclk)
  begin
    if (rst || !rdStrobe)
    begin
      rdData <= WORD_RST;
    end
    else
    begin
      case (addr)
        ADDR_CALC_CTRL:
        begin
          rdData <= {12'h000, 1'b0, (calcState == CALC_RUN), calcCtrl};
        end
        ADDR_TIMER_CTRL:
        begin
          rdData <= {8'h00, timerCtrl};
        end
        ADDR_PERIOD_SET:
        begin
          rdData <= periodSet;
        end
        ADDR_ANGLE:
        begin
          rdData <= {7'h00, angle};
        end
        ADDR_AMPLITUDE:
        begin
          rdData <= amplitude;
        end
        ADDR_CAPTURE:
        begin
          rdData <= {7'h00, capture};
        end
        ADDR_PWM_PERIOD:
        begin
          rdData <= pwmPeriod;
        end
        ADDR_CMP_U:
        begin
          rdData <= waveform_calc_enable ? result.u : duty.u;
        end
        ADDR_CMP_V:
        begin
          rdData <= waveform_calc_enable ? result.v : duty.v;
        end
        ADDR_CMP_W:
        begin
          rdData <= waveform_calc_enable ? result.w : duty.w;
        end
        default:
        begin
          rdData <= WORD_RST;
        end
      endcase
    end
  end

endmodule

/* File: sim/eawc_angle_calc_properties.sv */
`timescale 1ns/10ps
module eawc_angle_calc_properties
  import eawc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic posDetect,
  input wire logic angleIrq,
  input wire eawc_duty_t duty,
  input wire logic dutyLoad
);
  // ==========================================
  // Soft start tracking
  logic [5:0] calcCnt;
  logic xferOn;
  logic irqSel;
  always_ff @(posedge mclk)
  begin
    if (rst)
      calcCnt <= 6'h00;
    else if (wrStrobe && addr == ADDR_CALC_CTRL)
      calcCnt <= (wrData[CC_SOFT_START] && wrData[CC_SYNC_OFF]) ? 6'h01 : 6'h00;
    else if (calcCnt != 6'h00 && calcCnt != 6'h3f)
      calcCnt <= calcCnt + 6'h01;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      xferOn <= 1'b0;
      irqSel <= 1'b0;
    end
    else if (wrStrobe && addr == ADDR_TIMER_CTRL)
      xferOn <= wrData[TC_XFER] && wrData[TC_CALC_EN];
    else if (wrStrobe && addr == ADDR_CALC_CTRL)
      irqSel <= wrData[CC_IRQ_SEL];
  end
  // ==========================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_rd_ctrl;
    rdStrobe && addr == ADDR_CALC_CTRL;
  endsequence
  sequence s_running;
    calcCnt != 6'h00 && calcCnt < 6'h24;
  endsequence
  property p_irq_pulse; angleIrq |=> !angleIrq; endproperty
  property p_duty_hold; duty != $past(duty) |-> dutyLoad; endproperty
  property p_calc_len; calcCnt == 6'h24 && xferOn |-> dutyLoad; endproperty
  property p_no_early; s_running ##0 xferOn |-> !dutyLoad; endproperty
  property p_irq_end; angleIrq && irqSel && calcCnt != 6'h00 |-> calcCnt == 6'h24; endproperty
  property p_busy_on; s_rd_ctrl ##0 s_running |=> rdData[CC_BUSY]; endproperty
  property p_busy_off; s_rd_ctrl ##0 calcCnt >= 6'h24 |=> !rdData[CC_BUSY]; endproperty
  property p_angle_range; rdStrobe && addr == ADDR_ANGLE |=> rdData <= 16'h017f; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
  a_duty_hold: assert property (p_duty_hold) else $error("duty moved without load");
  a_calc_len: assert property (p_calc_len) else $error("no result after 35 cycles");
  a_no_early: assert property (p_no_early) else $error("result load too early");
  a_irq_end: assert property (p_irq_end) else $error("end irq at wrong cycle");
  a_busy_on: assert property (p_busy_on) else $error("busy low while running");
  a_busy_off: assert property (p_busy_off) else $error("busy high after end");
  a_angle_range: assert property (p_angle_range) else $error("angle above 383");
endmodule
bind eawc_angle_calc eawc_angle_calc_properties u_props (.mclk(mclk), .rst(rst), .addr(addr),
  .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
  .posDetect(posDetect), .angleIrq(angleIrq), .duty(duty), .dutyLoad(dutyLoad));

/* File: sim/eawc_pwm_model.sv */
`timescale 1ns/10ps
module eawc_pwm_model
  import eawc_pkg::*;
(
  input wire logic mclk,
  input wire eawc_duty_t duty,
  input wire logic dutyLoad,
  output logic posDetect
);
  // ==========================================
  // Duty latch of the PWM stage
  eawc_duty_t applied;
  initial applied = '0;
  initial posDetect = 1'b0;
  always @(posedge mclk)
  begin
    if (dutyLoad)
      applied <= duty;
  end
  task automatic pulse();
    @(posedge mclk);
    posDetect <= 1'b1;
    repeat (4) @(posedge mclk);
    posDetect <= 1'b0;
  endtask
endmodule

/* File: sim/test_eawc_angle_calc.sv */
`timescale 1ns/10ps
module test_eawc_angle_calc;
  import eawc_pkg::*;
  logic mclk, rst, wrStrobe, rdStrobe, posDetect, angleIrq, dutyLoad;
  logic [3:0] addr;
  logic [15:0] wrData, rdData, prd, voltage_amplitude;
  eawc_duty_t duty;
  int mismatches = 0;
  int checked = 0;
  eawc_angle_calc dut (.mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .posDetect(posDetect),
    .angleIrq(angleIrq), .duty(duty), .dutyLoad(dutyLoad));
  eawc_pwm_model pwm (.mclk(mclk), .duty(duty), .dutyLoad(dutyLoad), .posDetect(posDetect));
  // ==========================================
  // Helpers
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge mclk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    #1 check(rdData, e);
  endtask
  task automatic waitEv(input bit load, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end while ((load ? dutyLoad : angleIrq) !== 1'b1 && n < lim);
  endtask
  function automatic logic [15:0] sv(input logic [8:0] a);
    return {a, 7'h00};
  endfunction
  function automatic logic [15:0] ex(input logic [8:0] a, input logic three);
    logic [31:0] p;
    p = sv(a) * ((voltage_amplitude > prd) ? prd : voltage_amplitude);
    if (!three)
      return p[31:16];
    return (a < 9'h0c0) ? (prd >> 1) + (p[31:16] >> 1) : (prd >> 1) - (p[31:16] >> 1);
  endfunction
  // ==========================================
  // Scenarios
  task automatic runCalc(input logic [15:0] tc, input int u);
    int x;
    logic [15:0] e;
    wr(ADDR_TIMER_CTRL, tc);
    wr(ADDR_ANGLE, 16'(u));
    wr(ADDR_CALC_CTRL, 16'h000b);
    rdc(ADDR_CALC_CTRL, 16'h0007);
    repeat (33) @(posedge mclk);
    #1 check(16'(dutyLoad), 16'(tc[2]));
    check(16'(angleIrq), 16'h0001);
    for (int k = 0; k < 3; k++)
    begin
      x = tc[6] ? u + 384 - 128 * k : u + 128 * k;
      e = ex(9'(x % 384), tc[3]);
      rdc(ADDR_CMP_U + 4'(k), e);
      if (tc[2])
        check(pwm.applied[47 - 16 * k -: 16], e);
    end
    rdc(ADDR_CALC_CTRL, 16'h0003);
  endtask
  task automatic abortCalc();
    wr(ADDR_TIMER_CTRL, 16'h0006);
    wr(ADDR_CALC_CTRL, 16'h000b);
    repeat (10) @(posedge mclk);
    wr(ADDR_CALC_CTRL, 16'h000b);
    repeat (34) @(posedge mclk) #1 check(16'(dutyLoad), 16'h0000);
    @(posedge mclk) #1 check(16'(dutyLoad), 16'h0001);
  endtask
  task automatic cmpWrite();
    wr(ADDR_TIMER_CTRL, 16'h0000);
    wr(ADDR_CMP_V, 16'h1234);
    rdc(ADDR_CMP_V, 16'h1234);
    check(pwm.applied[31:16], 16'h1234);
    wr(ADDR_TIMER_CTRL, 16'h0006);
    wr(ADDR_CMP_V, 16'h4321);
    wr(ADDR_TIMER_CTRL, 16'h0000);
    rdc(ADDR_CMP_V, 16'h1234);
    check(pwm.applied[31:16], 16'h1234);
  endtask
  task automatic timerRun();
    int n;
    int s;
    wr(ADDR_CALC_CTRL, 16'h0002);
    wr(ADDR_PERIOD_SET, 16'h0005);
    wr(ADDR_ANGLE, 16'h017f);
    wr(ADDR_TIMER_CTRL, 16'h0001);
    waitEv(0, 5000, n);
    rdc(ADDR_ANGLE, 16'h0000);
    waitEv(0, 5000, n);
    waitEv(0, 5000, n);
    check(16'(n), 16'h0080);
    wr(ADDR_PERIOD_SET, 16'h2010);
    waitEv(0, 5000, n);
    s = 0;
    repeat (16)
    begin
      waitEv(0, 5000, n);
      s += n;
    end
    check(16'(s), 16'h0810);
    wr(ADDR_TIMER_CTRL, 16'h0011);
    waitEv(0, 5000, n);
    waitEv(0, 5000, n);
    check(16'(n), 16'h0100);
    wr(ADDR_TIMER_CTRL, 16'h0000);
    rdc(ADDR_ANGLE, 16'h0000);
    wr(ADDR_PERIOD_SET, 16'h0010);
    wr(ADDR_TIMER_CTRL, 16'h0081);
    waitEv(0, 5000, n);
    rdc(ADDR_ANGLE, 16'h017f);
    wr(ADDR_CALC_CTRL, 16'h0000);
    wr(ADDR_TIMER_CTRL, 16'h0007);
    waitEv(0, 5000, n);
    waitEv(1, 60, n);
    check(16'(n), 16'h0023);
    wr(ADDR_TIMER_CTRL, 16'h0006);
    wr(ADDR_ANGLE, 16'h0010);
    waitEv(1, 60, n);
    check(16'(n), 16'h0023);
    wr(ADDR_CALC_CTRL, 16'h0002);
    wr(ADDR_ANGLE, 16'h0020);
    waitEv(1, 60, n);
    check(16'(n), 16'h003c);
    pwm.pulse();
    repeat (4) @(posedge mclk);
    rdc(ADDR_CAPTURE, 16'h0020);
  endtask
  task automatic results();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    results();
  end
  initial
  begin
    rst = 1'b1;
    addr = 4'h0;
    wrData = 16'h0000;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    prd = 16'h1000;
    voltage_amplitude = 16'h0800;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rdc(ADDR_TIMER_CTRL, 16'h0000);
    rdc(ADDR_PERIOD_SET, 16'h0010);
    rdc(4'hf, 16'h0000);
    for (int a = 0; a < 384; a++)
    begin
      wr(ADDR_ANGLE, 16'(a));
      wr(ADDR_SINE_DATA, sv(9'(a)));
    end
    wr(ADDR_ANGLE, 16'h0180);
    rdc(ADDR_ANGLE, 16'h017f);
    wr(ADDR_PWM_PERIOD, prd);
    wr(ADDR_AMPLITUDE, voltage_amplitude);
    wr(ADDR_CALC_CTRL, 16'h0003);
    for (int t = 0; t < 4; t++)
      for (int j = 0; j < 4; j++)
        runCalc(t == 0 ? 16'h0006 : t == 1 ? 16'h000e : t == 2 ? 16'h004e : 16'h000a,
          j == 0 ? 0 : j == 1 ? 191 : j == 2 ? 192 : 383);
    voltage_amplitude = 16'hffff;
    wr(ADDR_AMPLITUDE, voltage_amplitude);
    runCalc(16'h0006, 100);
    abortCalc();
    cmpWrite();
    timerRun();
    results();
  end
endmodule
